// ### design/cal_alu.sv
`timescale 1ns/10ps
module cal_alu import cal_pkg::*; (
  // operation and operands
  input wire cal_kind_e op,
  input wire logic [7:0] dst,
  input wire logic [7:0] src,
  input wire cal_flags_s flags_in,
  // result
  output cal_alu_res_s res
);

  logic cin;
  logic [8:0] sum;
  logic [4:0] half;

  always_comb begin
    res.value = dst;
    res.flags = flags_in;
    cin = (op == K_ADC) & flags_in.c;
    sum = {1'b0, dst} + {1'b0, src} + {8'h00, cin};
    half = {1'b0, dst[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
    unique case (op)
      K_ADD, K_ADC: begin
        res.value = sum[7:0];
        res.flags.c = sum[8];
        res.flags.z = (sum[7:0] == 8'h00);
        res.flags.s = sum[7];
        res.flags.v = (dst[7] == src[7]) && (sum[7] != dst[7]);
        res.flags.d = 1'b0;
        res.flags.h = half[4];
      end
      K_AND: begin
        res.value = dst & src;
        res.flags.z = ((dst & src) == 8'h00);
        res.flags.s = dst[7] & src[7];
        res.flags.v = 1'b0;
      end
      K_CARRY_INV: begin
        res.flags.c = ~flags_in.c;
      end
      default: begin
        res.flags = flags_in;
      end
    endcase
  end

endmodule

// ### design/cal_exec_unit.sv
`timescale 1ns/10ps
module cal_exec_unit import cal_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // execution status
  output logic busy,
  output logic done
);

  // ==========================================================
  // state
  logic [7:0] rf_q [256];
  cal_flags_s flags_q;
  logic [15:0] pc_q;
  logic [7:0] stack_ptr_q;
  logic [23:0] instr_q;
  logic bad_q;
  cal_state_e state_q;
  cal_state_e state_d;
  logic [3:0] cnt_q;
  cal_dec_s dec_q;
  cal_dec_s dec_c;
  logic [7:0] src_q;
  logic [7:0] dstv_q;
  logic [7:0] dsta_q;
  logic [15:0] target_q;
  logic [7:0] src_c;
  logic [7:0] dsta_c;
  logic [15:0] target_c;
  logic [15:0] rtn_c;
  logic [7:0] stack_ptr_dec;
  cal_alu_res_s alu_res;
  logic is_call;
  logic is_alu;

  // ==========================================================
  // functions
  function automatic cal_dec_s decode(input logic [7:0] opc);
    cal_dec_s r;
    r.kind = K_BAD;
    r.len = LEN_1;
    r.cycles = CYC_SHORT;
    if ((opc[7:4] == NIB_ADD || opc[7:4] == NIB_ADC || opc[7:4] == NIB_AND) &&
        opc[3:0] >= FORM_RR && opc[3:0] <= FORM_LIT) begin
      if (opc[7:4] == NIB_ADD) begin
        r.kind = K_ADD;
      end else if (opc[7:4] == NIB_ADC) begin
        r.kind = K_ADC;
      end else begin
        r.kind = K_AND;
      end
      r.len = (opc[3:0] <= FORM_RIR) ? LEN_2 : LEN_3;
      r.cycles = (opc[3:0] == FORM_RR) ? CYC_SHORT : CYC_LONG;
    end else if (opc == OP_CALL_DIR) begin
      r.kind = K_CALL_DIR;
      r.len = LEN_3;
      r.cycles = CYC_CALL_DIR;
    end else if (opc == OP_CALL_IRR) begin
      r.kind = K_CALL_IRR;
      r.len = LEN_2;
      r.cycles = CYC_CALL_IRR;
    end else if (opc == OP_CARRY_INV) begin
      r.kind = K_CARRY_INV;
      r.len = LEN_1;
      r.cycles = CYC_CARRY_INV;
    end
    return r;
  endfunction

  // the flags register shows through the register file at its own address
  function automatic logic [7:0] rf_rd(input logic [7:0] a);
    return (a == FLAGS_ADDR) ? flags_q : rf_q[a];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // slave port: one wait cycle when idle, then the access is taken
  logic acc;
  logic wr_acc;
  logic grant;
  logic in_rf;
  logic [7:0] rf_idx;
  logic go_c;
  logic [31:0] rd_c;

  assign acc = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_acc = acc & avs_write;
  assign grant = (avs_read | avs_write) & avs_waitrequest & (state_q == ST_IDLE);
  assign in_rf = avs_address[RF_WIN_BIT] & (avs_address[1:0] == 2'b00);
  assign rf_idx = avs_address[9:2];
  assign go_c = wr_acc && avs_address == A_CTRL && avs_byteenable[0] &&
                avs_writedata[CTRL_START_BIT];

  always_comb begin
    rd_c = 32'h00000000;
    if (in_rf) begin
      rd_c = {24'h000000, rf_rd(rf_idx)};
    end else if (avs_address == A_INSTR) begin
      rd_c = {8'h00, instr_q};
    end else if (avs_address == A_PC) begin
      rd_c = {16'h0000, pc_q};
    end else if (avs_address == A_STACK_PTR) begin
      rd_c = {24'h000000, stack_ptr_q};
    end else if (avs_address == A_FLAGS) begin
      rd_c = {24'h000000, flags_q};
    end else if (avs_address == A_STATUS) begin
      rd_c[STATUS_BUSY_BIT] = busy;
      rd_c[STATUS_BAD_BIT] = bad_q;
    end
  end

  // waitrequest stays high while an instruction runs, so the master stalls
  always_ff @(posedge clock) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~grant;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (grant) begin
      avs_readdata <= rd_c;
    end
  end

  // ==========================================================
  // sequencer: busy lasts exactly the documented cycle count
  assign dec_c = decode(instr_q[7:0]);
  assign is_call = (dec_q.kind == K_CALL_DIR) || (dec_q.kind == K_CALL_IRR);
  assign is_alu = (dec_q.kind == K_ADD) || (dec_q.kind == K_ADC) || (dec_q.kind == K_AND);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: state_d = go_c ? ST_LOAD : ST_IDLE;
      ST_LOAD: state_d = ST_EXEC;
      ST_EXEC: state_d = is_call ? ST_PUSH : ST_WAIT;
      ST_PUSH: state_d = ST_WAIT;
      ST_WAIT: state_d = (cnt_q == dec_q.cycles) ? ST_IDLE : ST_WAIT;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'd0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_q == ST_IDLE) ? 4'd1 : cnt_q + 4'd1;
      busy <= (state_d != ST_IDLE);
      done <= (state_q == ST_WAIT) && (state_d == ST_IDLE);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dec_q <= '{kind: K_BAD, len: LEN_1, cycles: CYC_SHORT};
      bad_q <= 1'b0;
    end else if (go_c) begin
      dec_q <= dec_c;
      bad_q <= (dec_c.kind == K_BAD);
    end
  end

  // ==========================================================
  // operand fetch
  always_comb begin
    src_c = 8'h00;
    dsta_c = instr_q[15:8];
    unique case (instr_q[3:0])
      FORM_RR: begin
        dsta_c = WORK_BASE | {4'h0, instr_q[15:12]};
        src_c = rf_rd(WORK_BASE | {4'h0, instr_q[11:8]});
      end
      FORM_RIR: begin
        dsta_c = WORK_BASE | {4'h0, instr_q[15:12]};
        src_c = rf_rd(rf_rd(WORK_BASE | {4'h0, instr_q[11:8]}));
      end
      FORM_GG: begin
        dsta_c = instr_q[23:16];
        src_c = rf_rd(instr_q[15:8]);
      end
      FORM_GIR: begin
        dsta_c = instr_q[23:16];
        src_c = rf_rd(rf_rd(instr_q[15:8]));
      end
      default: begin
        src_c = instr_q[23:16];
      end
    endcase
  end

  // a pair names its high byte first, the low byte in the next register
  assign target_c = (dec_q.kind == K_CALL_IRR) ?
                    {rf_rd(instr_q[15:8]), rf_rd(instr_q[15:8] + 8'h01)} :
                    {instr_q[15:8], instr_q[23:16]};

  always_ff @(posedge clock) begin
    if (rst) begin
      src_q <= 8'h00;
      dstv_q <= 8'h00;
      dsta_q <= 8'h00;
      target_q <= 16'h0000;
    end else if (state_q == ST_LOAD) begin
      src_q <= src_c;
      dstv_q <= rf_rd(dsta_c);
      dsta_q <= dsta_c;
      target_q <= target_c;
    end
  end

  cal_alu u_alu (
    .op(dec_q.kind),
    .dst(dstv_q),
    .src(src_q),
    .flags_in(flags_q),
    .res(alu_res)
  );

  // ==========================================================
  // write back, stack and program counter
  assign rtn_c = pc_q + {14'h0000, dec_q.len};
  assign stack_ptr_dec = stack_ptr_q - 8'h01;

  // data memory, not reset; slave writes happen only while idle
  always_ff @(posedge clock) begin
    if (wr_acc && in_rf && avs_byteenable[0] && rf_idx != FLAGS_ADDR) begin
      rf_q[rf_idx] <= avs_writedata[7:0];
    end else if (state_q == ST_EXEC && is_alu && dsta_q != FLAGS_ADDR) begin
      rf_q[dsta_q] <= alu_res.value;
    end else if (state_q == ST_EXEC && is_call) begin
      rf_q[stack_ptr_dec] <= rtn_c[7:0];
    end else if (state_q == ST_PUSH) begin
      rf_q[stack_ptr_dec] <= rtn_c[15:8];
    end
  end

  // computed flags win over a result aimed at the flags address
  always_ff @(posedge clock) begin
    if (rst) begin
      flags_q <= FLAGS_RST;
    end else if (wr_acc && avs_byteenable[0] &&
                 (avs_address == A_FLAGS || (in_rf && rf_idx == FLAGS_ADDR))) begin
      flags_q <= avs_writedata[7:0];
    end else if (state_q == ST_EXEC && (is_alu || dec_q.kind == K_CARRY_INV)) begin
      flags_q <= alu_res.flags;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pc_q <= PC_RST;
    end else if (wr_acc && avs_address == A_PC) begin
      pc_q <= 16'(merge({16'h0000, pc_q}, avs_writedata, avs_byteenable));
    end else if (state_q == ST_EXEC && !is_call) begin
      pc_q <= rtn_c;
    end else if (state_q == ST_PUSH) begin
      pc_q <= target_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stack_ptr_q <= STACK_PTR_RST;
    end else if (wr_acc && avs_address == A_STACK_PTR && avs_byteenable[0]) begin
      stack_ptr_q <= avs_writedata[7:0];
    end else if ((state_q == ST_EXEC && is_call) || state_q == ST_PUSH) begin
      stack_ptr_q <= stack_ptr_dec;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      instr_q <= INSTR_RST;
    end else if (wr_acc && avs_address == A_INSTR) begin
      instr_q <= 24'(merge({8'h00, instr_q}, avs_writedata, avs_byteenable));
    end
  end

  // ==========================================================
  // checks
  logic [8:0] chk_sum;
  logic [4:0] chk_half;
  logic chk_add;
  logic chk_cin;

  assign chk_add = (state_q == ST_EXEC) && (dec_q.kind == K_ADD || dec_q.kind == K_ADC);
  assign chk_cin = (dec_q.kind == K_ADC) && flags_q.c;
  assign chk_sum = {1'b0, dstv_q} + {1'b0, src_q} + {8'h00, chk_cin};
  assign chk_half = {1'b0, dstv_q[3:0]} + {1'b0, src_q[3:0]} + {4'h0, chk_cin};

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  add_value_a: assert property (chk_add && dsta_q != FLAGS_ADDR |=>
    rf_q[dsta_q] == $past(chk_sum[7:0])) else $error("sum not stored");
  add_carry_a: assert property (chk_add |=> flags_q.c == $past(chk_sum[8]))
    else $error("carry flag wrong after add");
  add_ovf_a: assert property (chk_add |=> flags_q.v ==
    ($past(dstv_q[7]) == $past(src_q[7]) && $past(chk_sum[7]) != $past(dstv_q[7])))
    else $error("overflow flag wrong after add");
  add_zs_a: assert property (chk_add |=> flags_q.z == ($past(chk_sum[7:0]) == 8'h00)
    && flags_q.s == $past(chk_sum[7])) else $error("zero or sign wrong after add");
  add_dflag_a: assert property (chk_add |=> !flags_q.d)
    else $error("decimal flag not cleared");
  add_half_a: assert property (chk_add |=> flags_q.h == $past(chk_half[4]))
    else $error("half carry wrong");
  and_result_a: assert property (state_q == ST_EXEC && dec_q.kind == K_AND &&
    dsta_q != FLAGS_ADDR |=> rf_q[dsta_q] == ($past(dstv_q) & $past(src_q)))
    else $error("and result wrong");
  and_flags_a: assert property (state_q == ST_EXEC && dec_q.kind == K_AND |=>
    !flags_q.v && flags_q.c == $past(flags_q.c) && flags_q.h == $past(flags_q.h) &&
    flags_q.d == $past(flags_q.d) && flags_q.z == ($past(dstv_q & src_q) == 8'h00) &&
    flags_q.s == $past(dstv_q[7] & src_q[7])) else $error("and flags wrong");
  short_time_a: assert property (go_c && dec_c.cycles == 4'd4 |=>
    busy [*4] ##1 !busy) else $error("short instruction time wrong");
  long_time_a: assert property (go_c && dec_c.cycles == 4'd6 |=>
    busy [*6] ##1 !busy) else $error("long instruction time wrong");
  call_time_a: assert property (go_c && dec_c.kind == K_CALL_DIR |=>
    ##13 busy ##1 !busy) else $error("direct call time wrong");
  call_stack_a: assert property (state_q == ST_EXEC && is_call |->
    ##2 stack_ptr_q == $past(stack_ptr_q, 2) - 8'h02 && pc_q == target_q)
    else $error("call push wrong");
  call_rtn_a: assert property (state_q == ST_PUSH |=>
    {rf_q[stack_ptr_q], rf_q[8'(stack_ptr_q + 8'h01)]} == $past(rtn_c))
    else $error("return address wrong");
  call_flags_a: assert property (state_q == ST_EXEC && is_call |=>
    $stable(flags_q) ##1 $stable(flags_q)) else $error("call changed flags");
  carry_inv_a: assert property (state_q == ST_EXEC && dec_q.kind == K_CARRY_INV |=>
    flags_q.c != $past(flags_q.c) && flags_q[6:0] == $past(flags_q[6:0]))
    else $error("carry invert wrong");

endmodule

// ### design/cal_pkg.sv
package cal_pkg;

  // ==========================================================
  // register map, byte addresses on the slave port
  localparam logic [10:0] A_CTRL = 11'h000;
  localparam logic [10:0] A_INSTR = 11'h004;
  localparam logic [10:0] A_PC = 11'h008;
  localparam logic [10:0] A_STACK_PTR = 11'h00C;
  localparam logic [10:0] A_FLAGS = 11'h010;
  localparam logic [10:0] A_STATUS = 11'h014;
  // bit 10 set selects the register file window, one byte per word
  localparam int unsigned RF_WIN_BIT = 10;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_BAD_BIT = 1;

  // ==========================================================
  // register file addressing
  localparam logic [7:0] FLAGS_ADDR = 8'hD5;
  localparam logic [7:0] WORK_BASE = 8'hC0;

  // ==========================================================
  // reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] STACK_PTR_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [23:0] INSTR_RST = 24'h000000;

  // ==========================================================
  // opcodes and operand forms
  localparam logic [3:0] NIB_ADD = 4'h0;
  localparam logic [3:0] NIB_ADC = 4'h1;
  localparam logic [3:0] NIB_AND = 4'h5;
  localparam logic [3:0] FORM_RR = 4'h2;
  localparam logic [3:0] FORM_RIR = 4'h3;
  localparam logic [3:0] FORM_GG = 4'h4;
  localparam logic [3:0] FORM_GIR = 4'h5;
  localparam logic [3:0] FORM_LIT = 4'h6;
  localparam logic [7:0] OP_CALL_DIR = 8'hF6;
  localparam logic [7:0] OP_CALL_IRR = 8'hF4;
  localparam logic [7:0] OP_CARRY_INV = 8'hEF;

  // ==========================================================
  // lengths in bytes and execution times in cycles
  localparam logic [1:0] LEN_1 = 2'd1;
  localparam logic [1:0] LEN_2 = 2'd2;
  localparam logic [1:0] LEN_3 = 2'd3;
  localparam logic [3:0] CYC_SHORT = 4'd4;
  localparam logic [3:0] CYC_LONG = 4'd6;
  localparam logic [3:0] CYC_CALL_DIR = 4'd14;
  localparam logic [3:0] CYC_CALL_IRR = 4'd12;
  localparam logic [3:0] CYC_CARRY_INV = 4'd4;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    K_ADD = 3'b000,
    K_ADC = 3'b001,
    K_AND = 3'b010,
    K_CALL_DIR = 3'b011,
    K_CALL_IRR = 3'b100,
    K_CARRY_INV = 3'b101,
    K_BAD = 3'b110
  } cal_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_EXEC = 3'b010,
    ST_PUSH = 3'b011,
    ST_WAIT = 3'b100
  } cal_state_e;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
    logic [1:0] spare;
  } cal_flags_s;

  typedef struct packed {
    cal_kind_e kind;
    logic [1:0] len;
    logic [3:0] cycles;
  } cal_dec_s;

  typedef struct packed {
    logic [7:0] value;
    cal_flags_s flags;
  } cal_alu_res_s;

endpackage

// ### verif/cal_exec_unit_tb.sv
`timescale 1ns/10ps
module cal_exec_unit_tb import cal_pkg::*;;
  typedef struct packed {
    logic [7:0] op, dv, sv, fin, ed, ef;
  } cal_row_s;

  logic clock, rst, busy, done, avs_read, avs_write, avs_waitrequest, tmo;
  logic [10:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable, f;
  logic [7:0] da, sa, b1, b2;
  int error_cnt = 0;
  int samples_checked = 0;
  cal_row_s r;
  // opcode, dst, src, flags before, result, flags after (C Z S V D H)
  cal_row_s rows [15] = '{
    '{8'h02, 8'h8F, 8'h81, 8'h08, 8'h10, 8'h94}, '{8'h03, 8'h12, 8'h03, 8'h80, 8'h15, 8'h00},
    '{8'h04, 8'hFF, 8'h01, 8'h00, 8'h00, 8'hC4}, '{8'h05, 8'h08, 8'h08, 8'h3C, 8'h10, 8'h04},
    '{8'h06, 8'h40, 8'h40, 8'h80, 8'h80, 8'h30}, '{8'h12, 8'h10, 8'h03, 8'h80, 8'h14, 8'h00},
    '{8'h13, 8'h7F, 8'h00, 8'h80, 8'h80, 8'h34}, '{8'h14, 8'hFF, 8'h00, 8'h80, 8'h00, 8'hC4},
    '{8'h15, 8'h0A, 8'h05, 8'h7C, 8'h0F, 8'h00}, '{8'h16, 8'hF0, 8'h11, 8'h80, 8'h02, 8'h80},
    '{8'h52, 8'h12, 8'h03, 8'h9C, 8'h02, 8'h8C}, '{8'h53, 8'h0F, 8'hF0, 8'h10, 8'h00, 8'h40},
    '{8'h54, 8'hF3, 8'h81, 8'h00, 8'h81, 8'h20}, '{8'h55, 8'h21, 8'h0A, 8'h7C, 8'h00, 8'h4C},
    '{8'h56, 8'hFF, 8'h80, 8'h84, 8'h80, 8'hA4}};

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  cal_exec_unit u_cal_exec_unit (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .busy(busy), .done(done));
  cal_host_model u_cal_host_model (.clock(clock), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tmo(tmo));

  // ==========================================================
  // helpers
  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [10:0] ra(input logic [7:0] n);
    return {1'b1, n, 2'b00};
  endfunction

  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_cal_host_model.acc(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [10:0] a, output logic [31:0] d);
    u_cal_host_model.acc(1'b0, a, 32'h0, d);
  endtask

  // the first busy edge passes inside the bus task, so cyc-1 are seen here
  task automatic run(input logic [23:0] ins, input int cyc);
    int n;
    n = 0;
    wr(A_INSTR, {8'h00, ins});
    wr(A_CTRL, 32'h1);
    repeat (40) begin
      @(posedge clock);
      if (busy !== 1'b1) break;
      n++;
    end
    if (n >= 40) begin
      error_cnt++;
      final_report();
    end
    chk(n, cyc - 1);
    chk(done, 1'b1);
  endtask

  always @(posedge clock) begin
    if (tmo === 1'b1) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    #200000;
    error_cnt++;
    final_report();
  end

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    repeat (8) @(posedge clock);
    chk({avs_waitrequest, busy, done}, 3'b100);
    rst <= 1'b0;
    @(posedge clock);
    foreach (rows[i]) begin
      r = rows[i];
      f = r.op[3:0];
      case (f)
        FORM_RR: begin da = 8'hC1; sa = 8'hC2; b1 = 8'h12; b2 = 8'h00; end
        FORM_RIR: begin da = 8'hC1; sa = 8'h20; b1 = 8'h13; b2 = 8'h00; end
        FORM_GG: begin da = 8'h31; sa = 8'h30; b1 = 8'h30; b2 = 8'h31; end
        FORM_GIR: begin da = 8'h34; sa = 8'h33; b1 = 8'h32; b2 = 8'h34; end
        default: begin da = 8'h35; sa = 8'h36; b1 = 8'h35; b2 = r.sv; end
      endcase
      wr(ra(8'hC3), 32'h20);
      wr(ra(8'h32), 32'h33);
      wr(ra(sa), {24'h0, r.sv});
      wr(ra(da), {24'h0, r.dv});
      wr(A_FLAGS, {24'h0, r.fin});
      wr(A_PC, 32'h1000);
      run({b2, b1, r.op}, (f == FORM_RR) ? 4 : 6);
      rd(ra(da), q);
      chk(q[7:0], r.ed);
      rd(ra(sa), q);
      chk(q[7:0], r.sv);
      rd(A_FLAGS, q);
      chk(q[7:0], r.ef);
      rd(ra(FLAGS_ADDR), q);
      chk(q[7:0], r.ef);
      rd(A_PC, q);
      chk(q[15:0], (f <= FORM_RIR) ? 16'h1002 : 16'h1003);
    end
    // calls: direct then register pair, same return point rules
    for (int k = 0; k < 2; k++) begin
      wr(A_STACK_PTR, 32'hB2);
      wr(A_PC, 32'h1A47);
      wr(A_FLAGS, 32'hFC);
      wr(ra(8'hC0), 32'h15);
      wr(ra(8'hC1), 32'h21);
      run(k ? 24'h00C0F4 : 24'h2115F6, k ? 12 : 14);
      rd(A_PC, q);
      chk(q[15:0], 16'h1521);
      rd(A_STACK_PTR, q);
      chk(q[7:0], 8'hB0);
      rd(ra(8'hB1), q);
      chk(q[7:0], k ? 8'h49 : 8'h4A);
      rd(ra(8'hB0), q);
      chk(q[7:0], 8'h1A);
      rd(A_FLAGS, q);
      chk(q[7:0], 8'hFC);
    end
    // carry invert, the second time with a read that must stall
    wr(A_FLAGS, 32'h5C);
    wr(A_PC, 32'h0010);
    run(24'h0000EF, 4);
    rd(A_FLAGS, q);
    chk(q[7:0], 8'hDC);
    wr(A_INSTR, 32'hEF);
    wr(A_CTRL, 32'h1);
    rd(A_STATUS, q);
    chk(q[1:0], 2'b00);
    rd(A_FLAGS, q);
    chk(q[7:0], 8'h5C);
    rd(A_PC, q);
    chk(q[15:0], 16'h0012);
    // foreign opcode and an unmapped address
    run(24'h000007, 4);
    rd(A_STATUS, q);
    chk(q[1:0], 2'b10);
    rd(11'h020, q);
    chk(q, 32'h0);
    // second reset while a direct call is still running
    wr(A_INSTR, 32'hF6);
    wr(A_CTRL, 32'h1);
    repeat (3) @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({avs_waitrequest, busy, done}, 3'b100);
    rd(A_PC, q);
    chk(q[15:0], PC_RST);
    rd(A_FLAGS, q);
    chk(q[7:0], FLAGS_RST);
    rd(A_STACK_PTR, q);
    chk(q[7:0], STACK_PTR_RST);
    rd(A_INSTR, q);
    chk(q, {8'h00, INSTR_RST});
    final_report();
  end
endmodule

// ### verif/cal_host_model.sv
`timescale 1ns/10ps
module cal_host_model (
  // clock
  input wire logic clock,
  // avalon-mm master side
  output logic [10:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // hang flag
  output logic tmo
);
  // ==========================================================
  // bus cycles
  initial begin
    avs_address = 11'h7FC;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    tmo = 1'b0;
  end

  // held until waitrequest is sampled low; one idle edge after release
  // so that a following call never drives the strobes twice in a step
  task automatic acc(input logic w, input logic [10:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      tmo <= 1'b1;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released data lines show a changed pattern, not the old word
    avs_writedata <= ~d;
    avs_address <= ~a;
    @(posedge clock);
  endtask
endmodule
